// ===== src/eoe_encoder_output.sv
// Encoder feedback repeater driving quadrature A/B toward the host
// ********************************************************************
// ********************************************************************
module eoe_encoder_output
    import eoe_pkg::*;
(
    // Clock and reset
    input  wire logic                     SYS_CLK_I,
    input  wire logic                     RST_N_I,
    // Configuration
    input  wire eoe_cfg_type              CFG_I,
    // Digital quadrature feedback pins
    input  wire eoe_quad_type             ENC_QUAD_I,
    // Analog feedback, already digitised angle within one period
    input  wire logic [EOE_PHASE_W-1:0]   SINCOS_PHASE_I,
    // Output toward the control_signal_connector
    output      eoe_quad_type             CONN_QUAD_O,
    output      logic                     CONN_QUAD_OE_O,
    // Status
    output      logic [EOE_CPR_W-1:0]     COUNTS_PER_REV_O,
    output      logic                     RATIO_BAD_O
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    eoe_quad_type             quad_s1_q;   // First stage, read only below
    eoe_quad_type             quad_s2_q;   // Second stage
    eoe_quad_type             quad_prev_q; // Last seen state
    logic [EOE_PHASE_W-1:0]   ph_s1_q;     // Phase first stage
    logic [EOE_PHASE_W-1:0]   ph_s2_q;     // Phase second stage

    // Two flops on every pin before any logic looks at it
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            quad_s1_q   <= '0;
            quad_s2_q   <= '0;
            quad_prev_q <= '0;
            ph_s1_q     <= '0;
            ph_s2_q     <= '0;
        end
        else
        begin
            quad_s1_q   <= ENC_QUAD_I;
            quad_s2_q   <= quad_s1_q;
            quad_prev_q <= quad_s2_q;
            ph_s1_q     <= SINCOS_PHASE_I;
            ph_s2_q     <= ph_s1_q;
        end
    end

    // ****************************************************************
    // Step decode from either feedback source
    // ****************************************************************
    logic [1:0]             gray_now;   // Current digital state index
    logic [1:0]             gray_old;   // Previous digital state index
    logic [EOE_MULT_W-1:0]  mult_eff;   // Clamped multiplier
    logic [EOE_MULT_W-1:0]  count_now;  // Interpolated count in period
    logic [EOE_MULT_W-1:0]  count_q;    // Previous interpolated count
    logic [EOE_MULT_W-1:0]  fwd_dist;   // Forward distance in the period
    logic                   step_up;    // One count forward
    logic                   step_dn;    // One count backward

    // Quadrature pair to position index 0..3 (Gray order)
    function automatic logic [1:0] eoe_idx(input eoe_quad_type q);
        eoe_idx = {q.b, q.a ^ q.b};
    endfunction

    // Index back to the A/B pair
    function automatic eoe_quad_type eoe_pins(input logic [1:0] i);
        eoe_pins.b = i[1];
        eoe_pins.a = i[1] ^ i[0];
    endfunction

    assign gray_now = eoe_idx(quad_s2_q);
    assign gray_old = eoe_idx(quad_prev_q);

    // Multiplier is clamped to the largest legal factor
    assign mult_eff = (CFG_I.mult > EOE_MULT_MAX) ? EOE_MULT_MAX
                    : CFG_I.mult;

    // Phase scaled to counts; a 32-bit product keeps the top half
    logic [2*EOE_MULT_W-1:0] ph_prod;
    assign ph_prod   = ph_s2_q * mult_eff;
    assign count_now = ph_prod[2*EOE_MULT_W-1:EOE_MULT_W];

    // Distance forward round the period, so a wrap at the period end
    // reads as one step forward and not as a long way back
    assign fwd_dist = (count_now >= count_q) ? count_now - count_q
                    : count_now - count_q + mult_eff;

    // Remember the last interpolated count
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            count_q <= '0;
        else if (CFG_I.src == EOE_SRC_DIGITAL)
            // Kept aligned so a switch to analog replays no old steps
            count_q <= count_now;
        else if (step_up)
            count_q <= (count_q == mult_eff - 16'h0001) ? '0
                     : count_q + 16'h0001;
        else if (step_dn)
            count_q <= (count_q == '0) ? mult_eff - 16'h0001
                     : count_q - 16'h0001;
    end

    // One step per clock; analog tracks by single counts so a fast
    // move lags rather than skipping states
    always_comb
    begin
        step_up = 1'b0;
        step_dn = 1'b0;
        if (CFG_I.src == EOE_SRC_DIGITAL)
        begin
            // Digital feedback, forwarded one state at a time
            step_up = (gray_now == gray_old + 2'h1);
            step_dn = (gray_now == gray_old - 2'h1);
        end
        else if (mult_eff != '0 && count_now != count_q)
        begin
            // Analog: shortest way round the period
            if (fwd_dist < (mult_eff >> 1))
                step_up = 1'b1;
            else
                step_dn = 1'b1;
        end
    end

    // Rotary counts per revolution
    assign COUNTS_PER_REV_O = (CFG_I.src == EOE_SRC_ANALOG)
        ? CFG_I.periods * mult_eff : {EOE_CPR_W{1'b0}};

    // ****************************************************************
    // Ratio accumulator for emulated mode
    // ****************************************************************
    logic [EOE_RATIO_W-1:0] r_in;     // Input counts, zero means 1
    logic [EOE_RATIO_W-1:0] r_out;    // Output counts, zero means 1
    logic [EOE_RATIO_W+1:0] acc_q;    // Signed remainder accumulator
    logic [EOE_RATIO_W+1:0] acc_d;
    logic [EOE_RATIO_W+1:0] in_ext;
    logic [EOE_RATIO_W+1:0] out_ext;
    logic                   emu_up;   // Emit a forward output step
    logic                   emu_dn;   // Emit a backward output step

    // A zero term falls back to 1 (EOE_RATIO_DEF)
    assign r_in  = (CFG_I.ratio_in  == '0) ? EOE_RATIO_DEF
                 : CFG_I.ratio_in;
    assign r_out = (CFG_I.ratio_out == '0) ? EOE_RATIO_DEF
                 : CFG_I.ratio_out;
    assign in_ext  = {2'b00, r_in};
    assign out_ext = {2'b00, r_out};

    // Output faster than input would need several steps per clock
    assign RATIO_BAD_O = (r_out > r_in);

    // Each input count adds r_out; each r_in gives one output step
    always_comb
    begin
        acc_d  = acc_q;
        emu_up = 1'b0;
        emu_dn = 1'b0;
        if (step_up)
            acc_d = acc_q + out_ext;
        else if (step_dn)
            acc_d = acc_q - out_ext;
        if (!acc_d[EOE_RATIO_W+1] && acc_d >= in_ext)
        begin
            // Whole ratio gathered: one step forward, keep the rest
            emu_up = 1'b1;
            acc_d  = acc_d - in_ext;
        end
        else if (acc_d[EOE_RATIO_W+1])
        begin
            // Below zero: one step back, remainder positive again
            emu_dn = 1'b1;
            acc_d  = acc_d + in_ext;
        end
    end

    // Remainder is kept across steps so totals stay exact
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            acc_q <= '0;
        else if (CFG_I.out_mode != EOE_OUT_EMULATED)
            acc_q <= '0;
        else
            acc_q <= acc_d;
    end

    // ****************************************************************
    // Output state and pins
    // ****************************************************************
    logic [1:0] out_idx_q;   // Output Gray position
    logic       fwd;         // Forward step this clock
    logic       bwd;         // Backward step this clock

    // Only one source of steps is active at a time
    always_comb
    begin
        case (CFG_I.out_mode)
            EOE_OUT_BUFFERED:
            begin
                fwd = step_up;
                bwd = step_dn;
            end
            EOE_OUT_EMULATED:
            begin
                fwd = emu_up;
                bwd = emu_dn;
            end
            default:
            begin
                fwd = 1'b0;
                bwd = 1'b0;
            end
        endcase
    end

    // Invert reverses the count direction on the pins
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            out_idx_q <= EOE_GRAY_ZERO;
        else if (fwd ^ CFG_I.invert & (fwd | bwd))
            out_idx_q <= out_idx_q + 2'h1;
        else if (fwd | bwd)
            out_idx_q <= out_idx_q - 2'h1;
    end

    // Registered pins, enabled only on request
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            CONN_QUAD_O    <= '0;
            CONN_QUAD_OE_O <= 1'b0;
        end
        else
        begin
            CONN_QUAD_O    <= eoe_pins(out_idx_q);
            CONN_QUAD_OE_O <= CFG_I.enable;
        end
    end

endmodule // eoe_encoder_output

// ===== src/eoe_pkg.sv
// Package of constants and carrier types for the encoder output emulator
package eoe_pkg;

    // ****************************************************************
    // Widths and defaults
    // ****************************************************************
    localparam int          EOE_MULT_W        = 16;      // Multiplier width
    localparam logic [15:0] EOE_MULT_MAX      = 16'hfff8; // Largest factor
    localparam int          EOE_RATIO_W       = 16;      // Ratio term width
    localparam logic [15:0] EOE_RATIO_DEF     = 16'h0001; // Default 1:1
    localparam int          EOE_PERIODS_W     = 16;      // Periods per rev
    localparam int          EOE_CPR_W         = 32;      // Counts per rev
    localparam int          EOE_PHASE_W       = 16;      // Interpolator phase
    localparam logic [1:0]  EOE_GRAY_ZERO     = 2'h0;    // Quadrature state 0

    // ****************************************************************
    // Types
    // ****************************************************************
    // Feedback source selection
    typedef enum logic {EOE_SRC_DIGITAL, EOE_SRC_ANALOG} eoe_src_type;

    // Output generation selection, exactly one active
    typedef enum logic {EOE_OUT_BUFFERED, EOE_OUT_EMULATED} eoe_out_type;

    // Configuration carrier
    typedef struct packed {
        logic        enable;     // Drive the output pins
        eoe_out_type out_mode;   // Buffered or emulated
        logic        invert;     // Swap direction on the pins
        eoe_src_type src;        // Digital or analog feedback
        logic [EOE_MULT_W-1:0]    mult;     // Interpolation multiplier
        logic [EOE_PERIODS_W-1:0] periods;  // Sine periods per revolution
        logic [EOE_RATIO_W-1:0]   ratio_in; // Input counts per ratio step
        logic [EOE_RATIO_W-1:0]   ratio_out;// Output counts per ratio step
    } eoe_cfg_type;

    // Quadrature pair carrier
    typedef struct packed {
        logic a;
        logic b;
    } eoe_quad_type;

endpackage : eoe_pkg

// ===== verification/eoe_encoder_output_props.sv
// Concurrent checks on the encoder output emulator ports
module eoe_output_props
    import eoe_pkg::*;
(
    // Clock and reset
    input  wire logic                 SYS_CLK_I,
    input  wire logic                 RST_N_I,
    // Configuration and feedback
    input  wire eoe_cfg_type          CFG_I,
    input  wire eoe_quad_type         ENC_QUAD_I,
    input  wire logic [EOE_PHASE_W-1:0] SINCOS_PHASE_I,
    // Outputs under watch
    input  wire eoe_quad_type         CONN_QUAD_O,
    input  wire logic                 CONN_QUAD_OE_O,
    input  wire logic [EOE_CPR_W-1:0] COUNTS_PER_REV_O,
    input  wire logic                 RATIO_BAD_O
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // Helpers
    // ****************************************************************
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);
    logic [15:0] mult_eff;  // Multiplier after the clamp
    logic        buf_dig;   // Buffered digital pass-through with the output enabled
    assign mult_eff = (CFG_I.mult > EOE_MULT_MAX) ? EOE_MULT_MAX : CFG_I.mult;
    assign buf_dig  = CFG_I.enable && CFG_I.src == EOE_SRC_DIGITAL
                      && CFG_I.out_mode == EOE_OUT_BUFFERED;
    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_RESET_OUT: assert property ($rose(RST_N_I) |->
        CONN_QUAD_O == EOE_GRAY_ZERO && !CONN_QUAD_OE_O)
        else $error("outputs not idle after reset");
    AST_OE_ON: assert property (CFG_I.enable [*2] |-> CONN_QUAD_OE_O)
        else $error("output enable missing");
    AST_OE_OFF: assert property (!CFG_I.enable [*2] |-> !CONN_QUAD_OE_O)
        else $error("output enable stuck");
    AST_ONE_STEP: assert property ($countones(CONN_QUAD_O ^
        $past(CONN_QUAD_O)) <= 1) else $error("output jumped two states");
    AST_BUF_FOLLOW: assert property (buf_dig && $changed(ENC_QUAD_I)
        && $stable(CFG_I) |-> ##[2:6] $changed(CONN_QUAD_O))
        else $error("buffered step not forwarded");
    AST_IDLE_HOLD: assert property (($stable(ENC_QUAD_I) && $stable(CFG_I)
        && CFG_I.src == EOE_SRC_DIGITAL && !RATIO_BAD_O) [*8]
        |-> $stable(CONN_QUAD_O)) else $error("output moved with no input");
    AST_CPR_ANALOG: assert property (CFG_I.src == EOE_SRC_ANALOG |->
        COUNTS_PER_REV_O == 32'(CFG_I.periods) * 32'(mult_eff))
        else $error("counts per revolution wrong");
    AST_CPR_DIGITAL: assert property (CFG_I.src == EOE_SRC_DIGITAL |->
        COUNTS_PER_REV_O == 32'h0) else $error("digital counts not zero");
    AST_RATIO_BAD: assert property (CFG_I.ratio_in != 0 &&
        CFG_I.ratio_out != 0 |-> RATIO_BAD_O == (CFG_I.ratio_out >
        CFG_I.ratio_in)) else $error("ratio flag wrong");
    // Main scenarios seen
    COV_BUF: cover property (buf_dig && $changed(CONN_QUAD_O));
    COV_EMU: cover property (CFG_I.out_mode == EOE_OUT_EMULATED
        && $changed(CONN_QUAD_O));
    COV_ANA: cover property (CFG_I.src == EOE_SRC_ANALOG
        && $changed(CONN_QUAD_O));
endmodule // eoe_output_props

bind eoe_encoder_output eoe_output_props u_props (
    .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .CFG_I(CFG_I),
    .ENC_QUAD_I(ENC_QUAD_I), .SINCOS_PHASE_I(SINCOS_PHASE_I),
    .CONN_QUAD_O(CONN_QUAD_O), .CONN_QUAD_OE_O(CONN_QUAD_OE_O),
    .COUNTS_PER_REV_O(COUNTS_PER_REV_O), .RATIO_BAD_O(RATIO_BAD_O));

// ===== verification/eoe_host_model.sv
// Host controller model decoding quadrature feedback into a position
module eoe_host_model
    import eoe_pkg::*;
(
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Quadrature from the drive
    input  wire eoe_quad_type quad_i,
    input  wire logic         oe_i,
    // Decoded results
    output logic signed [31:0] pos_o,
    output logic [31:0]        jumps_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] prev_q; // Last state index
    logic [1:0] cur;    // Present state index, order 00,10,11,01
    assign cur = {quad_i.a ^ quad_i.b ^ 1'b0, 1'b0} == 2'h0 ?
                 {quad_i.b, 1'b0} : {quad_i.b, 1'b1};
    // Counts steps like a host counter; a skipped state is tallied
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prev_q  <= 2'h0;
            pos_o   <= '0;
            jumps_o <= '0;
        end
        else if (oe_i)
        begin
            prev_q <= cur;
            if (cur - prev_q == 2'h1) pos_o <= pos_o + 1;
            else if (cur - prev_q == 2'h3) pos_o <= pos_o - 1;
            else if (cur - prev_q == 2'h2) jumps_o <= jumps_o + 1;
        end
    end
endmodule // eoe_host_model

// ===== verification/tb.sv
// Self-checking bench for the encoder output emulator
module tb
    import eoe_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_n, oe, bad;
    eoe_cfg_type cfg;
    eoe_quad_type enc, q;
    logic [15:0] phase;
    logic [31:0] cpr, jumps;
    logic signed [31:0] pos, base;
    int miscompares, n_compared, idx;
    always #50 clk = ~clk;
    eoe_encoder_output dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CFG_I(cfg),
        .ENC_QUAD_I(enc), .SINCOS_PHASE_I(phase), .CONN_QUAD_O(q),
        .CONN_QUAD_OE_O(oe), .COUNTS_PER_REV_O(cpr), .RATIO_BAD_O(bad));
    eoe_host_model host (.clk_i(clk), .rst_n_i(rst_n), .quad_i(q),
        .oe_i(oe), .pos_o(pos), .jumps_o(jumps));
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic close_out();
        if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic mode(input logic em, inv, input logic [15:0] ri, ro);
        cfg.out_mode = eoe_out_type'(em);
        cfg.invert = inv;
        cfg.ratio_in = ri;
        cfg.ratio_out = ro;
        cyc(8);
        base = pos;
    endtask
    // Steps the feedback, spaced two clocks, then lets the output settle
    task automatic move(input int n, input int dir, input logic [31:0] e);
        repeat (n)
        begin
            idx += dir;
            enc = (idx & 3) == 0 ? 2'h0 : (idx & 3) == 1 ? 2'h2 :
                  (idx & 3) == 2 ? 2'h3 : 2'h1;
            cyc(2);
        end
        cyc(12);
        chk("position", e, pos - base);
        base = pos;
    endtask
    task automatic t_buffered();
        mode(0, 0, 16'h1, 16'h1);
        move(6, 1, 32'h6);
        move(3, -1, -32'sh3);
        mode(0, 1, 16'h1, 16'h1);
        move(5, 1, -32'sh5);
    endtask
    task automatic t_emulated();
        mode(1, 0, EOE_RATIO_DEF, EOE_RATIO_DEF);
        move(7, 1, 32'h7);
        mode(1, 0, 16'ha, 16'h1);
        move(40, 1, 32'h4);
        move(25, 1, 32'h2);
        move(5, 1, 32'h1);
        move(30, -1, -32'sh3);
        mode(1, 0, 16'h3, 16'h2);
        move(9, 1, 32'h6);
        mode(1, 1, 16'ha, 16'h1);
        move(20, 1, -32'sh2);
        chk("ratio flag", 32'h0, bad);
        mode(1, 0, 16'h1, 16'h2);
        chk("ratio flag", 32'h1, bad);
    endtask
    task automatic t_analog();
        mode(0, 0, 16'h1, 16'h1);
        cfg.src = EOE_SRC_ANALOG;
        cfg.periods = 16'h09c4;
        cfg.mult = 16'hfff8;
        cyc(1);
        chk("cpr", 32'h09c4 * 32'hfff8, cpr);
        cfg.mult = 16'hffff;
        cyc(1);
        chk("cpr clamp", 32'h09c4 * 32'hfff8, cpr);
        cfg.mult = 16'h4;
        cyc(8);
        base = pos;
        for (int i = 1; i < 4; i++)
        begin
            phase = 16'(i * 16384);
            cyc(6);
        end
        cyc(12);
        chk("interpolated", 32'h3, pos - base);
        cfg.src = EOE_SRC_DIGITAL;
        cyc(1);
        chk("cpr digital", 32'h0, cpr);
    endtask
    task automatic t_enable();
        cfg.enable = 0;
        cyc(3);
        chk("oe off", 32'h0, oe);
        cfg.enable = 1;
        cyc(3);
        chk("oe on", 32'h1, oe);
    endtask
    initial
    begin
        #500000;
        miscompares++;
        close_out();
    end
    initial
    begin
        clk = 0;
        rst_n = 0;
        enc = 2'h0;
        phase = 16'h0;
        cfg = '0;
        cfg.enable = 1;
        cfg.ratio_in = EOE_RATIO_DEF;
        cfg.ratio_out = EOE_RATIO_DEF;
        cyc(3);
        chk("reset quad", 32'h0, q);
        chk("reset oe", 32'h0, oe);
        cyc(1);
        rst_n = 1;
        cyc(4);
        t_enable();
        t_buffered();
        t_emulated();
        t_analog();
        chk("skipped states", 32'h0, jumps);
        close_out();
    end
endmodule // tb
